// *** rtl/jtm_map.svh ***
// Constants for the test access port with memory instructions
//
// Summary of operation
// - State changes on TMS at rising TCK only
// - Reset to identification; five TMS-high clocks reset
// - Select-DR holds registers; TMS picks capture or IR
// - Capture-DR loads selected register if loadable
// - Shift-DR shifts selected register toward TDO
// - Exit1-DR: high to update, low to pause
// - Pause-DR holds; exit2-DR to update or shift
// - Update-DR latches outputs on falling TCK
// - Select-IR holds; low capture, high reset
// - Capture-IR loads constant into instruction stage
// - Shift-IR shifts instruction stage, outputs stable
// - Exit1-IR to pause or update; pause holds
// - Exit2-IR: high to update, low to shift
// - Update-IR latches instruction on falling TCK
// - Decode 1Fh bypass, 00h identification, 03h user-code
// - Decode 04h address, 05h read, 06h write
// - Decode 07h restart, 08h fault store
// - Decode 09h/0Ah extended, 0Bh/0Ch nonvolatile page
// - Bypass uses a single-bit data register
// - Identification code: one, maker, part, version
// - User-code loads at capture-DR for shifting
// - User-code: ID byte low, slave address above
// - Memory instructions use an eight-bit data register
`ifndef JTM_MAP_SVH
`define JTM_MAP_SVH
`define JTM_IR_W 5
`define JTM_ID_W 32
`define JTM_MEM_W 8
`define JTM_RST_TMS 3'h5
`define JTM_IR_CAPTURE 5'h01
`define JTM_OP_IDCODE 5'h00
`define JTM_OP_USERCODE 5'h03
`define JTM_OP_LOAD_ADDR 5'h04
`define JTM_OP_MEM_READ 5'h05
`define JTM_OP_MEM_WRITE 5'h06
`define JTM_OP_REBOOT 5'h07
`define JTM_OP_SAVE 5'h08
`define JTM_OP_EXT_ENTER 5'h09
`define JTM_OP_EXT_LEAVE 5'h0a
`define JTM_OP_NVM_ENTER 5'h0b
`define JTM_OP_NVM_LEAVE 5'h0c
`define JTM_OP_BYPASS 5'h1f
`define JTM_ID_MAKER 11'h2a5 // Arbitrary value
`define JTM_ID_PART 16'h1234 // Arbitrary value
`define JTM_ID_VER 4'h1 // Arbitrary value
`endif

// *** rtl/jtm_pkg.sv ***
// Types for the test access port with memory instructions
package jtm_pkg;
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } jtm_state_t;
   typedef enum logic [2:0] {
      SEL_BYP, SEL_ID, SEL_USER, SEL_ADDR, SEL_RD, SEL_WR
   } jtm_dsel_t;
endpackage

// *** rtl/jtm_tap.sv ***
// Test access port controller with memory access instructions
`timescale 1ns/1ps
`default_nettype none
`include "jtm_map.svh"
module jtm_tap (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   output logic TDO,
   output logic TDO_OEN,
   input wire logic [7:0] USER_ID,
   input wire logic [6:0] SLAVE_ADDR,
   input wire logic [7:0] MEM_RDATA,
   output logic [7:0] MEM_ADDR,
   output logic [7:0] MEM_WDATA,
   output logic MEM_WR_REQ,
   output logic MEM_RD_REQ,
   output logic REBOOT_REQ,
   output logic SAVE_REQ,
   output logic EXT_PAGE,
   output logic NVM_PAGE,
   output logic [4:0] CUR_INSTR,
   output jtm_pkg::jtm_state_t TAP_STATE
);
   import jtm_pkg::*;

   jtm_state_t st_q, st_d;
   logic [`JTM_IR_W-1:0] ir_sh_q, ir_q;
   logic [`JTM_ID_W-1:0] id_sh_q;
   logic [`JTM_MEM_W-1:0] mem_sh_q, addr_q, wdata_q;
   logic byp_q, tdo_q, oen_q, ext_q, nvm_q;
   logic rd_tgl_q, wr_tgl_q, rbt_tgl_q, sav_tgl_q, adr_tgl_q;
   jtm_dsel_t dsel;
   logic tdo_d;
   logic [7:0] uid_s1_q, uid_s2_q, rdat_s1_q, rdat_s2_q;
   logic [6:0] sadr_s1_q, sadr_s2_q;

   // Configuration pins come from the system side; two TCK flops before
   // the user-code capture reads them
   always_ff @(posedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         uid_s1_q <= '0;
         uid_s2_q <= '0;
         sadr_s1_q <= '0;
         sadr_s2_q <= '0;
      end else begin
         uid_s1_q <= USER_ID;
         uid_s2_q <= uid_s1_q;
         sadr_s1_q <= SLAVE_ADDR;
         sadr_s2_q <= sadr_s1_q;
      end
   end

   // Read data also passes two TCK flops before capture-DR takes it
   always_ff @(posedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         rdat_s1_q <= '0;
         rdat_s2_q <= '0;
      end else begin
         rdat_s1_q <= MEM_RDATA;
         rdat_s2_q <= rdat_s1_q;
      end
   end

   // Next state follows TMS at rising TCK
   always_comb begin
      unique case (st_q)
         TLR: st_d = TMS ? TLR : RTI;
         RTI: st_d = TMS ? SEL_DR : RTI;
         SEL_DR: st_d = TMS ? SEL_IR : CAP_DR;
         CAP_DR: st_d = TMS ? EX1_DR : SH_DR;
         SH_DR: st_d = TMS ? EX1_DR : SH_DR;
         EX1_DR: st_d = TMS ? UPD_DR : PAU_DR;
         PAU_DR: st_d = TMS ? EX2_DR : PAU_DR;
         EX2_DR: st_d = TMS ? UPD_DR : SH_DR;
         UPD_DR: st_d = TMS ? SEL_DR : RTI;
         SEL_IR: st_d = TMS ? TLR : CAP_IR;
         CAP_IR: st_d = TMS ? EX1_IR : SH_IR;
         SH_IR: st_d = TMS ? EX1_IR : SH_IR;
         EX1_IR: st_d = TMS ? UPD_IR : PAU_IR;
         PAU_IR: st_d = TMS ? EX2_IR : PAU_IR;
         EX2_IR: st_d = TMS ? UPD_IR : SH_IR;
         UPD_IR: st_d = TMS ? SEL_DR : RTI;
      endcase
   end

   // TAP state; five TMS-high clocks always reach TLR
   always_ff @(posedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         st_q <= TLR;
      end else begin
         st_q <= st_d;
      end
   end

   // Data register selection by current instruction
   always_comb begin
      unique case (ir_q)
         `JTM_OP_IDCODE: dsel = SEL_ID;
         `JTM_OP_USERCODE: dsel = SEL_USER;
         `JTM_OP_LOAD_ADDR: dsel = SEL_ADDR;
         `JTM_OP_MEM_READ: dsel = SEL_RD;
         `JTM_OP_MEM_WRITE: dsel = SEL_WR;
         default: dsel = SEL_BYP;
      endcase
   end

   // Instruction shift stage
   always_ff @(posedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         ir_sh_q <= `JTM_IR_CAPTURE;
      end else if (st_q == CAP_IR) begin
         ir_sh_q <= `JTM_IR_CAPTURE;
      end else if (st_q == SH_IR) begin
         ir_sh_q <= {TDI, ir_sh_q[`JTM_IR_W-1:1]};
      end
   end

   // Instruction latch on falling TCK into update-IR
   always_ff @(negedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         ir_q <= `JTM_OP_IDCODE;
      end else if (st_q == TLR) begin
         ir_q <= `JTM_OP_IDCODE;
      end else if (st_q == UPD_IR) begin
         ir_q <= ir_sh_q;
      end
   end

   // Single-bit bypass register
   always_ff @(posedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         byp_q <= 1'b0;
      end else if (st_q == CAP_DR && dsel == SEL_BYP) begin
         byp_q <= 1'b0;
      end else if (st_q == SH_DR && dsel == SEL_BYP) begin
         byp_q <= TDI;
      end
   end

   // Identification and user-code shift register
   always_ff @(posedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         id_sh_q <= '0;
      end else if (st_q == CAP_DR && dsel == SEL_ID) begin
         id_sh_q <= {`JTM_ID_VER, `JTM_ID_PART, `JTM_ID_MAKER, 1'b1};
      end else if (st_q == CAP_DR && dsel == SEL_USER) begin
         id_sh_q <= {17'h0, sadr_s2_q, uid_s2_q};
      end else if (st_q == SH_DR && (dsel == SEL_ID || dsel == SEL_USER)) begin
         id_sh_q <= {TDI, id_sh_q[`JTM_ID_W-1:1]};
      end
   end

   // Eight-bit memory address, read and write shift register
   always_ff @(posedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         mem_sh_q <= '0;
      end else if (st_q == CAP_DR) begin
         unique case (dsel)
            SEL_ADDR: mem_sh_q <= addr_q;
            SEL_RD: mem_sh_q <= rdat_s2_q;
            SEL_WR: mem_sh_q <= wdata_q;
            default: mem_sh_q <= mem_sh_q;
         endcase
      end else if (st_q == SH_DR &&
                   (dsel == SEL_ADDR || dsel == SEL_RD || dsel == SEL_WR)) begin
         mem_sh_q <= {TDI, mem_sh_q[`JTM_MEM_W-1:1]};
      end
   end

   // Update-DR output latches on falling TCK
   always_ff @(negedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         addr_q <= '0;
         wdata_q <= '0;
      end else if (st_q == UPD_DR) begin
         if (dsel == SEL_ADDR) begin
            addr_q <= mem_sh_q;
         end
         if (dsel == SEL_WR) begin
            wdata_q <= mem_sh_q;
         end
      end
   end

   // Events on falling TCK become toggles, page selections levels, for the system clock
   always_ff @(negedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         rd_tgl_q <= 1'b0;
         wr_tgl_q <= 1'b0;
         rbt_tgl_q <= 1'b0;
         sav_tgl_q <= 1'b0;
         adr_tgl_q <= 1'b0;
         ext_q <= 1'b0;
         nvm_q <= 1'b0;
      end else begin
         if (st_q == UPD_DR && dsel == SEL_WR) begin
            wr_tgl_q <= ~wr_tgl_q;
         end
         if (st_q == UPD_DR && dsel == SEL_RD) begin
            rd_tgl_q <= ~rd_tgl_q;
         end
         if (st_q == UPD_DR && dsel == SEL_ADDR) begin
            adr_tgl_q <= ~adr_tgl_q;
         end
         if (st_q == UPD_IR) begin
            if (ir_sh_q == `JTM_OP_REBOOT) begin
               rbt_tgl_q <= ~rbt_tgl_q;
            end
            if (ir_sh_q == `JTM_OP_SAVE) begin
               sav_tgl_q <= ~sav_tgl_q;
            end
            if (ir_sh_q == `JTM_OP_EXT_ENTER) begin
               ext_q <= 1'b1;
            end
            if (ir_sh_q == `JTM_OP_EXT_LEAVE) begin
               ext_q <= 1'b0;
            end
            if (ir_sh_q == `JTM_OP_NVM_ENTER) begin
               nvm_q <= 1'b1;
            end
            if (ir_sh_q == `JTM_OP_NVM_LEAVE) begin
               nvm_q <= 1'b0;
            end
         end
      end
   end

   // TDO mux, changes on falling TCK, driven only while shifting
   always_comb begin
      tdo_d = byp_q;
      if (st_q == SH_IR) begin
         tdo_d = ir_sh_q[0];
      end else if (dsel == SEL_ID || dsel == SEL_USER) begin
         tdo_d = id_sh_q[0];
      end else if (dsel != SEL_BYP) begin
         tdo_d = mem_sh_q[0];
      end
   end

   always_ff @(negedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         tdo_q <= 1'b0;
         oen_q <= 1'b1;
      end else begin
         tdo_q <= tdo_d;
         oen_q <= !(st_q == SH_DR || st_q == SH_IR);
      end
   end

   // Crossing into the system clock: two flops, then edge detect
   localparam int NX = 7;
   logic [NX-1:0] x_src, x_s1_q, x_s2_q, x_s3_q;
   assign x_src = {adr_tgl_q, nvm_q, ext_q, sav_tgl_q, rbt_tgl_q, rd_tgl_q,
                   wr_tgl_q};

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         x_s1_q <= '0;
         x_s2_q <= '0;
         x_s3_q <= '0;
      end else begin
         x_s1_q <= x_src;
         x_s2_q <= x_s1_q;
         x_s3_q <= x_s2_q;
      end
   end

   // Words are read only once their toggle has crossed; by then they have
   // stood still for more than a CLK cycle, so no bit is caught moving
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         MEM_ADDR <= '0;
      end else if (x_s2_q[6] ^ x_s3_q[6]) begin
         MEM_ADDR <= addr_q;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         MEM_WDATA <= '0;
      end else if (x_s2_q[0] ^ x_s3_q[0]) begin
         MEM_WDATA <= wdata_q;
      end
   end

   // Requests last one CLK cycle per event
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         MEM_WR_REQ <= 1'b0;
         MEM_RD_REQ <= 1'b0;
         REBOOT_REQ <= 1'b0;
         SAVE_REQ <= 1'b0;
      end else begin
         MEM_WR_REQ <= x_s2_q[0] ^ x_s3_q[0];
         MEM_RD_REQ <= x_s2_q[1] ^ x_s3_q[1];
         REBOOT_REQ <= x_s2_q[2] ^ x_s3_q[2];
         SAVE_REQ <= x_s2_q[3] ^ x_s3_q[3];
      end
   end

   // Page selections are levels
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         EXT_PAGE <= 1'b0;
         NVM_PAGE <= 1'b0;
      end else begin
         EXT_PAGE <= x_s2_q[4];
         NVM_PAGE <= x_s2_q[5];
      end
   end

   // The instruction has no toggle, as a port reset may replace it twice
   // in quick succession; it is taken only when two successive
   // synchronised samples agree, so a torn word never shows
   logic [`JTM_IR_W-1:0] ir_s1_q, ir_s2_q, ir_s3_q;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         ir_s1_q <= `JTM_OP_IDCODE;
         ir_s2_q <= `JTM_OP_IDCODE;
         ir_s3_q <= `JTM_OP_IDCODE;
      end else begin
         ir_s1_q <= ir_q;
         ir_s2_q <= ir_s1_q;
         ir_s3_q <= ir_s2_q;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         CUR_INSTR <= `JTM_OP_IDCODE;
      end else if (ir_s2_q == ir_s3_q) begin
         CUR_INSTR <= ir_s3_q;
      end
   end

   assign TDO = tdo_q;
   assign TDO_OEN = oen_q;
   assign TAP_STATE = st_q;
endmodule
`default_nettype wire

// *** dv/jtm_tap_checker.sv ***
// Checker for the test access port
`timescale 1ns/1ps
`default_nettype none
module jtm_tap_checker (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDO_OEN,
   input wire logic MEM_WR_REQ,
   input wire logic REBOOT_REQ,
   input wire logic SAVE_REQ,
   input wire jtm_pkg::jtm_state_t TAP_STATE
);
   import jtm_pkg::*;
   five_high_a: assert property (@(posedge TCK) disable iff (!RSTN)
      TMS [*5] |=> TAP_STATE == TLR) else $error("no reset");
   sel_dr_a: assert property (@(posedge TCK) disable iff (!RSTN)
      TAP_STATE == SEL_DR |=> TAP_STATE == ($past(TMS) ? SEL_IR : CAP_DR))
      else $error("bad select-DR exit");
   exit1_dr_a: assert property (@(posedge TCK) disable iff (!RSTN)
      TAP_STATE == EX1_DR |=> TAP_STATE == ($past(TMS) ? UPD_DR : PAU_DR))
      else $error("bad exit1-DR exit");
   pause_dr_a: assert property (@(posedge TCK) disable iff (!RSTN)
      TAP_STATE == PAU_DR && !TMS |=> TAP_STATE == PAU_DR)
      else $error("left pause-DR");
   sel_ir_a: assert property (@(posedge TCK) disable iff (!RSTN)
      TAP_STATE == SEL_IR |=> TAP_STATE == ($past(TMS) ? TLR : CAP_IR))
      else $error("bad select-IR exit");
   upd_next_a: assert property (@(posedge TCK) disable iff (!RSTN)
      TAP_STATE inside {UPD_DR, UPD_IR} |=>
      TAP_STATE == ($past(TMS) ? SEL_DR : RTI)) else $error("bad update exit");
   oen_shift_a: assert property (@(posedge TCK) disable iff (!RSTN)
      TDO_OEN == !(TAP_STATE inside {SH_DR, SH_IR}))
      else $error("TDO enable outside shift");
   req_pulse_a: assert property (@(posedge CLK) disable iff (!RSTN)
      REBOOT_REQ || SAVE_REQ |=> !REBOOT_REQ && !SAVE_REQ)
      else $error("request longer than one cycle");
   c_pause: cover property (@(posedge TCK) TAP_STATE == PAU_IR);
   c_upd: cover property (@(posedge TCK) TAP_STATE == UPD_IR);
   c_wr: cover property (@(posedge CLK) MEM_WR_REQ);
endmodule
bind jtm_tap jtm_tap_checker chk (.CLK, .RSTN, .TCK, .TMS, .TDO_OEN,
   .MEM_WR_REQ, .REBOOT_REQ, .SAVE_REQ, .TAP_STATE);
`default_nettype wire

// *** dv/jtm_jtag_master.sv ***
// Model of the external scan master
`timescale 1ns/1ps
`default_nettype none
module jtm_jtag_master (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // TMS and TDI move only while TCK is low
   task automatic clk1(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #6 o = tdo;
      tck = 1'b1;
      #6 tck = 1'b0;
   endtask
   // Outside shifting TDI toggles so stale bits never pass for data
   task automatic nav(input logic m);
      logic o;
      clk1(m, ~tdi, o);
   endtask
   task automatic rst5();
      repeat (5) nav(1'b1);
   endtask
   // Idle, IR or DR scan of n bits LSB first, update, idle
   task automatic scan(input logic ir, input int n, input logic [31:0] d,
         output logic [31:0] q);
      logic o;
      q = 32'h0;
      nav(1'b0);
      nav(1'b1);
      if (ir)
         nav(1'b1);
      nav(1'b0);
      nav(1'b0);
      for (int i = 0; i < n; i++) begin
         clk1(i == n - 1, d[i], o);
         q[i] = o;
      end
      nav(1'b1);
      nav(1'b0);
   endtask
endmodule
`default_nettype wire

// *** dv/jtm_tap_bench.sv ***
// Self-checking bench for the test access port
`timescale 1ns/1ps
`default_nettype none
`include "jtm_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
   $display("Error at %0t got %h expected %h", $time, g, e); end end
module jtm_tap_bench;
   import jtm_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic tck, tms, tdi, tdo, tdo_oen, tdo_pin;
   logic [7:0] user_id = 8'h5e;
   logic [6:0] slave_addr = 7'h2b;
   logic [7:0] mem_rdata = 8'h96;
   logic [7:0] mem_addr, mem_wdata;
   logic wr_req, rd_req, boot_req, save_req, ext_page, nvm_page;
   logic [4:0] cur_instr;
   jtm_state_t tap_state;
   int errors = 0;
   int compares = 0;
   int cnt [4] = '{0, 0, 0, 0};
   always #50 clk = ~clk;
   // Count only once reset has settled the request outputs
   always @(posedge clk) begin
      if (rstn) begin
         cnt[0] <= cnt[0] + wr_req;
         cnt[1] <= cnt[1] + rd_req;
         cnt[2] <= cnt[2] + boot_req;
         cnt[3] <= cnt[3] + save_req;
      end
   end
   // Pull-up holds the released TDO line high
   assign tdo_pin = tdo_oen ? 1'b1 : tdo;
   jtm_tap uut (.CLK(clk), .RSTN(rstn), .TCK(tck), .TMS(tms), .TDI(tdi),
      .TDO(tdo), .TDO_OEN(tdo_oen), .USER_ID(user_id),
      .SLAVE_ADDR(slave_addr), .MEM_RDATA(mem_rdata), .MEM_ADDR(mem_addr),
      .MEM_WDATA(mem_wdata), .MEM_WR_REQ(wr_req), .MEM_RD_REQ(rd_req),
      .REBOOT_REQ(boot_req), .SAVE_REQ(save_req), .EXT_PAGE(ext_page),
      .NVM_PAGE(nvm_page), .CUR_INSTR(cur_instr), .TAP_STATE(tap_state));
   jtm_jtag_master m (.tck, .tms, .tdi, .tdo(tdo_pin));
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   task automatic ld(input logic [4:0] c);
      logic [31:0] q;
      m.scan(1'b1, 5, {27'h0, c}, q);
      `CHK(q[4:0], `JTM_IR_CAPTURE)
      idle(10);
      `CHK(cur_instr, c)
   endtask
   task automatic dr(input int n, input logic [31:0] d, output logic [31:0] q);
      m.scan(1'b0, n, d, q);
      idle(10);
   endtask
   task automatic t_id();
      logic [31:0] q;
      dr(32, 32'h0, q);
      `CHK(q, {`JTM_ID_VER, `JTM_ID_PART, `JTM_ID_MAKER, 1'b1})
      ld(`JTM_OP_USERCODE);
      dr(32, 32'h0, q);
      `CHK(q, {17'h0, slave_addr, user_id})
      $display("code tests done");
   endtask
   task automatic t_byp();
      logic [31:0] q;
      logic [4:0] c [2] = '{`JTM_OP_BYPASS, 5'h15};
      for (int i = 0; i < 2; i++) begin
         ld(c[i]);
         dr(8, 32'ha5, q);
         `CHK(q[7:0], 8'h4a)
      end
      $display("bypass test done");
   endtask
   task automatic t_mem();
      logic [31:0] q;
      ld(`JTM_OP_LOAD_ADDR);
      dr(8, 32'h3c, q);
      `CHK(mem_addr, 8'h3c)
      ld(`JTM_OP_MEM_WRITE);
      dr(8, 32'h5a, q);
      `CHK(mem_wdata, 8'h5a)
      `CHK(cnt[0], 1)
      ld(`JTM_OP_MEM_READ);
      dr(8, 32'h0, q);
      `CHK(q[7:0], mem_rdata)
      `CHK(cnt[1], 1)
      $display("memory test done");
   endtask
   task automatic t_ctl();
      ld(`JTM_OP_REBOOT);
      `CHK(cnt[2], 1)
      ld(`JTM_OP_SAVE);
      `CHK(cnt[3], 1)
      ld(`JTM_OP_EXT_ENTER);
      `CHK(ext_page, 1'b1)
      ld(`JTM_OP_NVM_ENTER);
      `CHK(nvm_page, 1'b1)
      ld(`JTM_OP_EXT_LEAVE);
      `CHK(ext_page, 1'b0)
      ld(`JTM_OP_NVM_LEAVE);
      `CHK(nvm_page, 1'b0)
      $display("control test done");
   endtask
   task automatic t_walk();
      logic [21:0] s = 22'b1111101010111101001001;
      jtm_state_t e [22] = '{SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, PAU_DR,
         EX2_DR, SH_DR, EX1_DR, UPD_DR, SEL_DR, SEL_IR, CAP_IR, EX1_IR,
         PAU_IR, EX2_IR, SH_IR, EX1_IR, UPD_IR, SEL_DR, SEL_IR, TLR};
      m.nav(1'b0);
      for (int i = 0; i < 22; i++) begin
         m.nav(s[i]);
         `CHK(tap_state, e[i])
      end
      idle(10);
      `CHK(cur_instr, `JTM_OP_IDCODE)
      m.nav(1'b0);
      m.nav(1'b1);
      m.nav(1'b0);
      m.nav(1'b0);
      m.rst5();
      `CHK(tap_state, TLR)
      $display("walk test done");
   endtask
   task automatic test_done();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #400us;
      errors++;
      test_done();
   end
   initial begin
      m.rst5();
      idle(20);
      rstn = 1'b1;
      t_id();
      t_byp();
      t_mem();
      t_ctl();
      t_walk();
      test_done();
   end
endmodule
`default_nettype wire
